/* File: rtl/rfcpc_checker.sv */
// Parameter checker for the tag side: polling match, descriptor, command list checks
`timescale 1ns/1ns
module rfcpc_checker
  import rfcpc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Block results
  output logic poll_respond,
  output logic mem_access_grant
);
  import rfcpc_pkg::*;

  // Register state
  logic [15:0] stored_system_code_q;
  logic [63:0] card_identifier_area_q;
  logic [15:0] timing_q;
  logic poll_done_q;
  logic poll_respond_q;
  rfcpc_state_t state_q;
  logic is_write_q;
  logic [4:0] svc_cnt_q;
  logic [15:0] first_svc_q;
  logic svc_diff_q;
  logic [4:0] blk_cnt_q;
  logic [2:0] first_mode_q;
  logic [7:0] prev_blk_q;
  logic blk_spec_err_q;
  logic [7:0] flag1_q;
  logic [7:0] flag2_q;
  logic grant_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // APB phase decode
  wire setup_w = psel & ~penable;
  wire access_w = psel & penable & pready_q;
  wire wr_w = access_w & pwrite;
  wire hit_code = paddr == OFS_STORED_CODE;
  wire hit_idl = paddr == OFS_CARD_ID_LO;
  wire hit_idh = paddr == OFS_CARD_ID_HI;
  wire hit_tim = paddr == OFS_TIMING;
  wire hit_preq = paddr == OFS_POLL_REQ;
  wire hit_pst = paddr == OFS_POLL_STAT;
  wire hit_dlo = paddr == OFS_DESC_LO;
  wire hit_dhi = paddr == OFS_DESC_HI;
  wire hit_ctl = paddr == OFS_CMD_CTRL;
  wire hit_svc = paddr == OFS_SVC_ENTRY;
  wire hit_blk = paddr == OFS_BLK_ELEM;
  wire hit_cst = paddr == OFS_CMD_STAT;
  wire mapped_w = hit_code | hit_idl | hit_idh | hit_tim | hit_preq | hit_pst | hit_dlo
    | hit_dhi | hit_ctl | hit_svc | hit_blk | hit_cst;

  // Polling match against stored code
  wire [15:0] req_code_w = pwdata[15:0];
  wire code_match_w = (req_code_w == CODE_WILDCARD)
    | ((req_code_w == CODE_CLASS_REQ) & (stored_system_code_q[15:8] == CODE_CLASS_UPPER))
    | (req_code_w == stored_system_code_q);

  // Response-time descriptor, D0 in low byte
  wire [63:0] desc_w = {DESC_ONES, timing_q[15:8], timing_q[7:0], DESC_ZERO, DESC_ZERO,
    DESC_ZERO, DESC_ONES, DESC_ONES};

  // Command control decode
  wire start_w = wr_w & hit_ctl & pwdata[CTRL_START_BIT];
  wire finish_w = wr_w & hit_ctl & pwdata[CTRL_FINISH_BIT] & (state_q == ST_COLLECT);
  wire svc_wr_w = wr_w & hit_svc & (state_q == ST_COLLECT);
  wire blk_wr_w = wr_w & hit_blk & (state_q == ST_COLLECT);

  // Block element fields
  wire [7:0] el_d0_w = pwdata[7:0];
  wire [7:0] el_num_w = pwdata[ELEM_D1_LSB +: 8];
  wire [7:0] el_d2_w = pwdata[ELEM_D2_LSB +: 8];
  wire el_three_w = pwdata[ELEM_THREE_BIT];
  wire [2:0] el_mode_w = el_three_w ? el_d2_w[2:0] : MODE_RF;
  wire el_acc_err_w = el_d0_w[6:4] != 3'h0;
  wire el_pad_err_w = el_three_w & (el_d2_w[7:3] != 5'h00);
  wire el_rsv_err_w = (el_mode_w != MODE_RF) & (el_mode_w != MODE_TUNNEL);
  wire el_mix_err_w = (blk_cnt_q != 5'h00) & (el_mode_w != first_mode_q);
  wire el_range_err_w = (el_mode_w == MODE_RF) & (el_num_w >= NV_BLOCKS);
  // Tunnel lists must step by one with 8-bit wrap; RF lists may be in any order
  wire [7:0] next_num_w = prev_blk_q + 8'h01;
  wire el_order_err_w = (el_mode_w == MODE_TUNNEL) & (blk_cnt_q != 5'h00)
    & (el_num_w != next_num_w);
  wire el_err_w = el_acc_err_w | el_pad_err_w | el_rsv_err_w | el_mix_err_w
    | el_range_err_w | el_order_err_w;

  // Limit evaluation at finish
  wire tunnel_w = first_mode_q == MODE_TUNNEL;
  wire [4:0] svc_max_w = is_write_q ? MAX_SVC_WRITE : MAX_SVC_READ;
  wire svc_cnt_err_w = (svc_cnt_q == 5'h00) | (svc_cnt_q > svc_max_w);
  wire [4:0] blk_max_w = is_write_q ? ((svc_cnt_q <= SVC_SPLIT) ? MAX_BLK_WRITE_LO
    : MAX_BLK_WRITE_HI) : (tunnel_w ? MAX_BLK_READ_TUN : MAX_BLK_READ_RF);
  wire blk_cnt_err_w = (blk_cnt_q == 5'h00) | (blk_cnt_q > blk_max_w);
  wire [7:0] code_w = svc_cnt_err_w ? CODE_SVC_COUNT : svc_diff_q ? CODE_SVC_DIFF
    : blk_cnt_err_w ? CODE_BLK_COUNT : blk_spec_err_q ? CODE_BLK_SPEC : FLAG_OK;
  wire pass_w = code_w == FLAG_OK;

  // Read data selection; slot field stays zero
  wire [31:0] rd_w = hit_code ? {16'h0000, stored_system_code_q}
    : hit_idl ? card_identifier_area_q[31:0]
    : hit_idh ? card_identifier_area_q[63:32]
    : hit_tim ? {16'h0000, timing_q}
    : hit_pst ? {30'h0000_0000, poll_respond_q, poll_done_q}
    : hit_dlo ? desc_w[31:0]
    : hit_dhi ? desc_w[63:32]
    : hit_cst ? {13'h0000, tunnel_w, grant_q, state_q == ST_DONE, flag2_q, flag1_q}
    : 32'h0000_0000;

  // APB answer: one wait-free access after each setup
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;
      prdata_q <= (setup_w & ~pwrite) ? rd_w : 32'h0000_0000;
    end
  end

  // Stored configuration loaded by software from nonvolatile copies
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stored_system_code_q <= STORED_CODE_RESET;
      card_identifier_area_q <= CARD_ID_RESET;
      timing_q <= TIMING_RESET;
    end
    else
    begin
      if (wr_w & hit_code)
        stored_system_code_q <= pwdata[15:0];
      if (wr_w & hit_idl)
        card_identifier_area_q[31:0] <= pwdata;
      if (wr_w & hit_idh)
        card_identifier_area_q[63:32] <= pwdata;
      if (wr_w & hit_tim)
        timing_q <= pwdata[15:0];
    end
  end

  // Polling decision on each request write
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      poll_done_q <= 1'b0;
      poll_respond_q <= 1'b0;
    end
    else if (wr_w & hit_preq)
    begin
      poll_done_q <= 1'b1;
      poll_respond_q <= code_match_w;
    end
  end

  // Command collection state
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      is_write_q <= 1'b0;
    end
    else if (start_w)
    begin
      state_q <= ST_COLLECT;
      is_write_q <= pwdata[CTRL_WRITE_BIT];
    end
    else
    begin
      case (state_q)
        ST_IDLE: state_q <= ST_IDLE;
        ST_COLLECT: state_q <= finish_w ? ST_DONE : ST_COLLECT;
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Service list tracking
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      svc_cnt_q <= 5'h00;
      first_svc_q <= 16'h0000;
      svc_diff_q <= 1'b0;
    end
    else if (start_w)
    begin
      svc_cnt_q <= 5'h00;
      svc_diff_q <= 1'b0;
    end
    else if (svc_wr_w)
    begin
      if (svc_cnt_q != CNT_SAT)
        svc_cnt_q <= svc_cnt_q + 5'h01;
      if (svc_cnt_q == 5'h00)
        first_svc_q <= pwdata[15:0];
      else if (pwdata[15:0] != first_svc_q)
        svc_diff_q <= 1'b1;
    end
  end

  // Block list tracking
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      blk_cnt_q <= 5'h00;
      first_mode_q <= MODE_RF;
      prev_blk_q <= 8'h00;
      blk_spec_err_q <= 1'b0;
    end
    else if (start_w)
    begin
      blk_cnt_q <= 5'h00;
      first_mode_q <= MODE_RF;
      blk_spec_err_q <= 1'b0;
    end
    else if (blk_wr_w)
    begin
      if (blk_cnt_q != CNT_SAT)
        blk_cnt_q <= blk_cnt_q + 5'h01;
      if (blk_cnt_q == 5'h00)
        first_mode_q <= el_mode_w;
      prev_blk_q <= el_num_w;
      if (el_err_w)
        blk_spec_err_q <= 1'b1;
    end
  end

  // Final status; memory access only after every check has passed
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      flag1_q <= FLAG_OK;
      flag2_q <= FLAG_OK;
      grant_q <= 1'b0;
    end
    else if (start_w)
    begin
      flag1_q <= FLAG_OK;
      flag2_q <= FLAG_OK;
      grant_q <= 1'b0;
    end
    else if (finish_w)
    begin
      flag1_q <= pass_w ? FLAG_OK : FLAG_ERR;
      flag2_q <= code_w;
      grant_q <= pass_w;
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign poll_respond = poll_respond_q;
  assign mem_access_grant = grant_q;

  // Checks on the behaviour above
  chk_poll_wild: assert property (@(posedge clock) disable iff (!resetn)
    (wr_w & hit_preq & (pwdata[15:0] == CODE_WILDCARD)) |=> poll_respond_q)
    else $error("wildcard poll not answered");
  chk_poll_class: assert property (@(posedge clock) disable iff (!resetn)
    (wr_w & hit_preq & (pwdata[15:0] == CODE_CLASS_REQ)) |=>
    (poll_respond_q == (stored_system_code_q[15:8] == CODE_CLASS_UPPER)))
    else $error("class poll answer wrong");
  chk_poll_exact: assert property (@(posedge clock) disable iff (!resetn)
    (wr_w & hit_preq & (pwdata[15:0] != CODE_WILDCARD) & (pwdata[15:0] != CODE_CLASS_REQ)
    & (pwdata[15:0] != stored_system_code_q)) |=> !poll_respond_q)
    else $error("poll answered without match");
  chk_desc_fixed: assert property (@(posedge clock) disable iff (!resetn)
    (setup_w & ~pwrite & hit_dlo) |=> (prdata[15:0] == 16'hFFFF)
    && (prdata[31:16] == 16'h0000))
    else $error("descriptor fixed bytes wrong");
  chk_desc_timing: assert property (@(posedge clock) disable iff (!resetn)
    (setup_w & ~pwrite & hit_dhi) |=> (prdata[23:8] == $past(timing_q))
    && (prdata[7:0] == 8'h00) && (prdata[31:24] == 8'hFF))
    else $error("descriptor timing bytes not copied");
  chk_slot_zero: assert property (@(posedge clock) disable iff (!resetn)
    (setup_w & ~pwrite & hit_pst) |=> (prdata[9:8] == 2'h0))
    else $error("poll answer not in first slot");
  chk_ident_load: assert property (@(posedge clock) disable iff (!resetn)
    (wr_w & hit_idl) |=> (card_identifier_area_q[31:0] == $past(pwdata)))
    else $error("identifier word not stored");
  chk_svc_limit: assert property (@(posedge clock) disable iff (!resetn)
    (finish_w & ~is_write_q & (svc_cnt_q == 5'h10)) |=> (flag2_q == 8'hA1))
    else $error("service limit not flagged");
  chk_svc_differ: assert property (@(posedge clock) disable iff (!resetn)
    (svc_wr_w & (svc_cnt_q != 5'h00) & (pwdata[15:0] != first_svc_q)) |=> svc_diff_q)
    else $error("differing service not flagged");
  chk_wblk_limit: assert property (@(posedge clock) disable iff (!resetn)
    (finish_w & is_write_q & ~svc_cnt_err_w & ~svc_diff_q & (svc_cnt_q > 5'h08)
    & (blk_cnt_q == 5'h0C)) |=> (flag2_q == 8'hA2))
    else $error("write block limit not flagged");
  chk_rblk_limit: assert property (@(posedge clock) disable iff (!resetn)
    (finish_w & ~is_write_q & ~tunnel_w & (blk_cnt_q == 5'h0E)) |=> (flag1_q == 8'hFF))
    else $error("read block limit not flagged");
  chk_access_bits: assert property (@(posedge clock) disable iff (!resetn)
    (blk_wr_w & (pwdata[6:4] != 3'h0)) |=> blk_spec_err_q)
    else $error("access bits not flagged");
  chk_pad_bits: assert property (@(posedge clock) disable iff (!resetn)
    (blk_wr_w & pwdata[ELEM_THREE_BIT] & (pwdata[ELEM_D2_LSB + 3 +: 5] != 5'h00))
    |=> blk_spec_err_q)
    else $error("third byte pad bits not flagged");
  chk_mode_reserved: assert property (@(posedge clock) disable iff (!resetn)
    (blk_wr_w & pwdata[ELEM_THREE_BIT] & (pwdata[ELEM_D2_LSB +: 3] != MODE_RF)
    & (pwdata[ELEM_D2_LSB +: 3] != MODE_TUNNEL)) |=> blk_spec_err_q)
    else $error("reserved mode not flagged");
  chk_mode_mixed: assert property (@(posedge clock) disable iff (!resetn)
    (blk_wr_w & (blk_cnt_q != 5'h00) & (el_mode_w != first_mode_q)) |=> blk_spec_err_q)
    else $error("mixed modes not flagged");
  chk_tunnel_order: assert property (@(posedge clock) disable iff (!resetn)
    (blk_wr_w & (el_mode_w == MODE_TUNNEL) & (blk_cnt_q != 5'h00)
    & (el_num_w != prev_blk_q + 8'h01)) |=> blk_spec_err_q)
    else $error("tunnel order break missed");
  chk_pass_flags: assert property (@(posedge clock) disable iff (!resetn)
    (finish_w & ~svc_cnt_err_w & ~svc_diff_q & ~blk_cnt_err_w & ~blk_spec_err_q)
    |=> (flag1_q == 8'h00) && (flag2_q == 8'h00) && grant_q)
    else $error("clean command not ended normally");
  chk_grant_pass: assert property (@(posedge clock) disable iff (!resetn)
    $rose(grant_q) |-> (flag1_q == 8'h00) && (flag2_q == 8'h00) && $past(finish_w))
    else $error("access granted without clean check");
  cov_poll_hit: cover property (@(posedge clock) disable iff (!resetn) $rose(poll_respond_q));
  cov_tunnel_pass: cover property (@(posedge clock) disable iff (!resetn)
    $rose(grant_q) & tunnel_w);
  cov_spec_err: cover property (@(posedge clock) disable iff (!resetn)
    finish_w ##1 (flag2_q == 8'hA5));
  cov_write_pass: cover property (@(posedge clock) disable iff (!resetn)
    $rose(grant_q) & is_write_q);
  cov_svc_diff: cover property (@(posedge clock) disable iff (!resetn)
    finish_w ##1 (flag2_q == 8'hA3));
endmodule

/* File: rtl/rfcpc_pkg.sv */
// Constants, register map and types for the RF command parameter checker
package rfcpc_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_STORED_CODE = 8'h00;
  localparam logic [7:0] OFS_CARD_ID_LO = 8'h04;
  localparam logic [7:0] OFS_CARD_ID_HI = 8'h08;
  localparam logic [7:0] OFS_TIMING = 8'h0C;
  localparam logic [7:0] OFS_POLL_REQ = 8'h10;
  localparam logic [7:0] OFS_POLL_STAT = 8'h14;
  localparam logic [7:0] OFS_DESC_LO = 8'h18;
  localparam logic [7:0] OFS_DESC_HI = 8'h1C;
  localparam logic [7:0] OFS_CMD_CTRL = 8'h20;
  localparam logic [7:0] OFS_SVC_ENTRY = 8'h24;
  localparam logic [7:0] OFS_BLK_ELEM = 8'h28;
  localparam logic [7:0] OFS_CMD_STAT = 8'h2C;
  // CMD_CTRL bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_FINISH_BIT = 2;
  // Block element field positions
  localparam int ELEM_D1_LSB = 8;
  localparam int ELEM_D2_LSB = 16;
  localparam int ELEM_THREE_BIT = 24;
  // Poll status and command status field positions
  localparam int POLL_DONE_BIT = 0;
  localparam int POLL_RESP_BIT = 1;
  localparam int STAT_F2_LSB = 8;
  localparam int STAT_DONE_BIT = 16;
  localparam int STAT_GRANT_BIT = 17;
  localparam int STAT_TUNNEL_BIT = 18;
  // Reset values
  localparam logic [15:0] STORED_CODE_RESET = 16'h0000;
  localparam logic [63:0] CARD_ID_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] TIMING_RESET = 16'h0000;
  // System code matching
  localparam logic [15:0] CODE_WILDCARD = 16'hFFFF;
  localparam logic [15:0] CODE_CLASS_REQ = 16'hAAFF;
  localparam logic [7:0] CODE_CLASS_UPPER = 8'hAA;
  // Response-time descriptor fixed bytes
  localparam logic [7:0] DESC_ONES = 8'hFF;
  localparam logic [7:0] DESC_ZERO = 8'h00;
  // Communication mode codes in third element byte
  localparam logic [2:0] MODE_RF = 3'h0;
  localparam logic [2:0] MODE_TUNNEL = 3'h4;
  // Limits
  localparam logic [4:0] MAX_SVC_READ = 5'h0F;
  localparam logic [4:0] MAX_SVC_WRITE = 5'h0B;
  localparam logic [4:0] MAX_BLK_READ_RF = 5'h0D;
  localparam logic [4:0] MAX_BLK_READ_TUN = 5'h0F;
  localparam logic [4:0] MAX_BLK_WRITE_LO = 5'h0C;
  localparam logic [4:0] MAX_BLK_WRITE_HI = 5'h0B;
  localparam logic [4:0] SVC_SPLIT = 5'h08;
  localparam logic [4:0] CNT_SAT = 5'h1F;
  localparam logic [7:0] NV_BLOCKS = 8'h20;
  localparam int BLOCK_BYTES = 16;
  // Status flag pairs
  localparam logic [7:0] FLAG_OK = 8'h00;
  localparam logic [7:0] FLAG_ERR = 8'hFF;
  localparam logic [7:0] CODE_SVC_COUNT = 8'hA1;
  localparam logic [7:0] CODE_BLK_COUNT = 8'hA2;
  localparam logic [7:0] CODE_SVC_DIFF = 8'hA3;
  localparam logic [7:0] CODE_BLK_SPEC = 8'hA5;
  // Command collection states
  typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_DONE} rfcpc_state_t;
endpackage

/* File: verification/rfcpc_reader.sv */
// Reader-side model that reaches the tag block over its APB register port
`timescale 1ns/1ns
module rfcpc_reader
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Longest wait the reader allows for one command, in carrier periods
  function automatic longint max_wait_fc(input int a, input int b, input int e, input int n);
    max_wait_fc = 64'h1000 * ((b + 1) * n + (a + 1)) * (4 ** e);
  endfunction

  // One transfer: setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    begin
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clock);
        n++;
      end
      while (pready !== 1'b1 && n < 64);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;  // Released data does not keep its old value
      if (pready !== 1'b1)
      begin
        tb_rfcpc_checker.err_count++;
        tb_rfcpc_checker.give_verdict();
      end
    end
  endtask
endmodule

/* File: verification/tb_rfcpc_checker.sv */
// Self-checking bench for the tag command parameter checker
`timescale 1ns/1ns
module tb_rfcpc_checker;
  import rfcpc_pkg::*;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr, ev;
  logic poll_respond, mem_access_grant;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  int err_count, checks;
  logic [15:0] p_code [6] = '{16'h1234, 16'h1234, 16'hAA55, 16'hAB55, 16'h1234, 16'hAAFF};
  logic [15:0] p_rq [6] = '{16'hFFFF, 16'h1235, 16'hAAFF, 16'hAAFF, 16'h1234, 16'hAAFE};
  logic p_ex [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] TUN = {5'h0, MODE_TUNNEL};

  rfcpc_checker dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .poll_respond(poll_respond), .mem_access_grant(mem_access_grant));
  rfcpc_reader rdr (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register write and checked read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rdr.xfer(1'b1, a, d, rv, ev);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rdr.xfer(1'b0, a, 32'h0, rv, ev);
    chk(nm, rv, exp);
  endtask

  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One command: fault 1 makes the last service differ, 2 replaces the last element
  task automatic cmd(input logic w, input int ns, input int nb, input logic [7:0] base,
    input logic [7:0] d2, input logic three, input int fault, input logic [31:0] fv,
    input logic [7:0] code);
    logic [31:0] el;
    logic ok;
    begin
      ok = (code === FLAG_OK);
      wr(OFS_CMD_CTRL, {30'h0, w, 1'b1});
      rdr.xfer(1'b0, OFS_CMD_STAT, 32'h0, rv, ev);
      chk("grant_clr", {31'h0, rv[STAT_GRANT_BIT]}, 32'h0);
      for (int i = 0; i < ns; i++)
        wr(OFS_SVC_ENTRY, (fault == 1 && i == ns - 1) ? 32'h000A : 32'h0009);
      for (int i = 0; i < nb; i++)
      begin
        el = {7'h0, three, d2, base + 8'(i), 8'h00};
        if (fault == 2 && i == nb - 1)
          el = fv;
        wr(OFS_BLK_ELEM, el);
      end
      wr(OFS_CMD_CTRL, 32'h4);
      rdr.xfer(1'b0, OFS_CMD_STAT, 32'h0, rv, ev);
      chk("cmd_stat", rv & 32'h3FFFF, ok ? 32'h30000 : {16'h1, code, FLAG_ERR});
      if (ok)
        chk("tunnel", 32'(rv[STAT_TUNNEL_BIT]), 32'(three && d2[2:0] == MODE_TUNNEL));
      chk("grant_port", {31'h0, mem_access_grant}, {31'h0, ok});
    end
  endtask

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("code_rst", OFS_STORED_CODE, 32'h0);
    rd_chk("tim_rst", OFS_TIMING, 32'h0);
    wr(OFS_TIMING, 32'h3412);
    wr(OFS_DESC_LO, 32'h0);
    rd_chk("desc_lo", OFS_DESC_LO, {DESC_ZERO, DESC_ZERO, DESC_ONES, DESC_ONES});
    rd_chk("desc_hi", OFS_DESC_HI, {DESC_ONES, 8'h34, 8'h12, DESC_ZERO});
    chk("max_wait", 32'(rdr.max_wait_fc(1, 0, 1, 3)), 32'h0001_4000);
    wr(OFS_CARD_ID_LO, 32'h89AB_CDEF);
    wr(OFS_CARD_ID_HI, 32'h0123_4567);
    rd_chk("id_lo", OFS_CARD_ID_LO, 32'h89AB_CDEF);
    rd_chk("id_hi", OFS_CARD_ID_HI, 32'h0123_4567);
    rdr.xfer(1'b1, 8'h30, 32'h1, rv, ev);
    chk("slverr", {31'h0, ev}, 32'h1);
    rd_chk("unmapped", 8'h30, 32'h0);
    // Polling matches: wildcard, class, exact and misses
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_STORED_CODE, {16'h0, p_code[i]});
      wr(OFS_POLL_REQ, {16'h0, p_rq[i]});
      rd_chk("poll_stat", OFS_POLL_STAT, {30'h0, p_ex[i], 1'b1});
      chk("poll_port", {31'h0, poll_respond}, {31'h0, p_ex[i]});
    end
    // Counts at and beyond each limit
    cmd(0, 1, 13, 8'h00, 8'h00, 0, 0, 0, FLAG_OK);
    cmd(0, 1, 14, 8'h00, 8'h00, 0, 0, 0, CODE_BLK_COUNT);
    cmd(0, 15, 15, 8'hF8, TUN, 1, 0, 0, FLAG_OK);
    cmd(0, 1, 16, 8'h00, TUN, 1, 0, 0, CODE_BLK_COUNT);
    cmd(0, 16, 1, 8'h00, 8'h00, 0, 0, 0, CODE_SVC_COUNT);
    cmd(1, 11, 11, 8'h00, 8'h00, 0, 0, 0, FLAG_OK);
    cmd(1, 12, 1, 8'h00, 8'h00, 0, 0, 0, CODE_SVC_COUNT);
    cmd(1, 8, 12, 8'h00, 8'h00, 0, 0, 0, FLAG_OK);
    cmd(1, 9, 12, 8'h00, 8'h00, 0, 0, 0, CODE_BLK_COUNT);
    cmd(1, 8, 13, 8'h00, TUN, 1, 0, 0, CODE_BLK_COUNT);
    cmd(0, 0, 1, 8'h00, 8'h00, 0, 0, 0, CODE_SVC_COUNT);
    cmd(0, 3, 2, 8'h00, 8'h00, 0, 1, 0, CODE_SVC_DIFF);
    // Element field faults
    cmd(0, 1, 2, 8'h00, 8'h00, 0, 2, 32'h0000_0110, CODE_BLK_SPEC);
    cmd(0, 1, 1, 8'h00, 8'h08, 1, 0, 0, CODE_BLK_SPEC);
    for (int m = 1; m < 8; m++)
      if (m != 4)
        cmd(0, 1, 1, 8'h00, {5'h0, 3'(m)}, 1, 0, 0, CODE_BLK_SPEC);
    cmd(0, 1, 3, 8'h10, TUN, 1, 2, 32'h0104_1400, CODE_BLK_SPEC);
    cmd(0, 1, 3, 8'h10, 8'h00, 0, 2, 32'h0000_0500, FLAG_OK);
    cmd(0, 1, 2, 8'h1E, 8'h00, 0, 0, 0, FLAG_OK);
    cmd(0, 1, 2, 8'h1F, 8'h00, 0, 0, 0, CODE_BLK_SPEC);
    cmd(0, 1, 2, 8'h10, TUN, 1, 2, 32'h0000_1100, CODE_BLK_SPEC);
    cmd(0, 1, 2, 8'h10, 8'h00, 1, 0, 0, FLAG_OK);
    give_verdict();
  end
endmodule
